// ---- hdl/pmvc_power_ctrl.v ----
`timescale 1ns/10ps
`include "pmvc_regs.vh"

module pmvc_power_ctrl #(
	parameter STAB_CYCLES = `PMVC_STAB_CYCLES
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// CPU core instruction interface
	input wire cpu_halt_instr,
	input wire cpu_wait_instr,
	input wire cpu_instr_end,
	input wire cpu_irq_mask,
	output reg cpu_irq_mask_clr,
	output reg cpu_irq_take,
	output reg [15:0] cpu_vector,
	output reg cpu_reset_fetch,
	// Interrupt sources
	input wire port_group_a_pin,
	input wire port_group_b_pin,
	input wire [2:0] motor_irq,
	input wire spi_irq,
	input wire timer_one_irq,
	input wire timer_two_irq,
	// Clocks and enables
	output wire osc_enable,
	output wire cpu_clk_en,
	output wire periph_clk_en,
	output wire motor_serial_clk_en,
	output wire [3:0] power_state
);
	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	localparam [3:0] ST_RUN = 4'h1;
	localparam [3:0] ST_WAIT = 4'h2;
	localparam [3:0] ST_HALT = 4'h4;
	localparam [3:0] ST_STAB = 4'h8;

	reg [3:0] state_q;
	reg [12:0] stab_q;
	reg wake_reset_q;
	reg [2:0] misc_q;
	reg pga_q;
	reg pgb_q;
	reg pga_prev_q;
	reg pgb_prev_q;
	reg aw_done_q;
	reg w_done_q;
	reg [3:0] awaddr_q;
	reg [31:0] wdata_q;
	reg wstrb_lo_q;
	wire [7:0] req;
	wire [7:0] grant;
	wire [15:0] vector;
	wire any_req;
	wire halt_wake;
	wire cpu_tick;
	wire periph_tick;
	wire ms_tick;
	wire wr_fire;

	// ------------------------------------------------------------
	// Request collection
	// ------------------------------------------------------------
	// Port groups come from their edge latches; the other sources are levels
	// that stay up until their owners clear them.
	// three motor requests
	// all eight slots hold request inputs
	assign req = {timer_two_irq, timer_one_irq, spi_irq, motor_irq[2],
		motor_irq[1], motor_irq[0], pgb_q, pga_q};
	assign halt_wake = pga_q | pgb_q;

	pmvc_irq_prio u_prio (
		.req(req),
		.any(any_req),
		.grant(grant),
		.vector(vector)
	);

	always @(posedge aclk) begin
		if (!aresetn) begin
			pga_q <= 1'b0;
			pgb_q <= 1'b0;
			pga_prev_q <= 1'b0;
			pgb_prev_q <= 1'b0;
		end else begin
			pga_prev_q <= port_group_a_pin;
			pgb_prev_q <= port_group_b_pin;
			// A new edge wins over the clear in the same cycle.
			if (port_group_a_pin && !pga_prev_q) begin
				pga_q <= 1'b1;
			end else if (cpu_irq_take && grant[0]) begin
				pga_q <= 1'b0;
			end
			if (port_group_b_pin && !pgb_prev_q) begin
				pgb_q <= 1'b1;
			end else if (cpu_irq_take && grant[1]) begin
				pgb_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Power mode sequencer
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_RUN;
			stab_q <= 13'h0000;
			wake_reset_q <= 1'b0;
			cpu_irq_mask_clr <= 1'b0;
			cpu_irq_take <= 1'b0;
			cpu_vector <= `PMVC_VEC_RESET;
			cpu_reset_fetch <= 1'b1;
		end else begin
			cpu_irq_mask_clr <= 1'b0;
			cpu_irq_take <= 1'b0;
			cpu_reset_fetch <= 1'b0;
			case (state_q)
				ST_RUN: begin
					if (cpu_halt_instr) begin
						state_q <= ST_HALT;
						cpu_irq_mask_clr <= 1'b1;
					end else if (cpu_wait_instr || misc_q[`PMVC_BIT_WAITREQ]) begin
						state_q <= ST_WAIT;
						cpu_irq_mask_clr <= 1'b1;
					end else if (any_req && !cpu_irq_mask && cpu_instr_end) begin
						cpu_irq_take <= 1'b1;
						cpu_vector <= vector;
					end
				end
				ST_WAIT: begin
					if (any_req) begin
						state_q <= ST_RUN;
						cpu_irq_take <= 1'b1;
						cpu_vector <= vector;
					end
				end
				ST_HALT: begin
					// Reset leaves HALT through the synchronous reset itself, so only
					// an interrupt is ever recorded here as the cause.
					// restart on wake
					if (halt_wake) begin
						state_q <= ST_STAB;
						stab_q <= 13'h0000;
						wake_reset_q <= 1'b0;
					end
				end
				ST_STAB: begin
					// Only CPU ticks are counted, so the delay stays in CPU cycles
					// whichever divider SLOW mode has selected.
					if (cpu_tick) begin
						if (stab_q == STAB_CYCLES - 1) begin
							state_q <= ST_RUN;
							if (wake_reset_q) begin
								cpu_reset_fetch <= 1'b1;
								cpu_vector <= `PMVC_VEC_RESET;
							end else begin
								cpu_irq_take <= 1'b1;
								cpu_vector <= vector;
							end
						end else begin
							stab_q <= stab_q + 13'h0001;
						end
					end
				end
				default: state_q <= ST_RUN;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Clock generation
	// ------------------------------------------------------------
	// oscillator off in halt
	assign osc_enable = (state_q != ST_HALT);

	// Both dividers restart from zero when the oscillator returns, so the
	// first enable after HALT comes one full period after the restart.
	// slow select
	pmvc_clk_div u_cpu_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(osc_enable),
		.div_i(misc_q[`PMVC_BIT_SLOW] ? `PMVC_DIV_SLOW : `PMVC_DIV_RUN),
		.tick(periph_tick)
	);

	pmvc_clk_div u_ms_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(osc_enable),
		.div_i(misc_q[`PMVC_BIT_MSCLK] ? `PMVC_DIV_FAST : `PMVC_DIV_RUN),
		.tick(ms_tick)
	);

	// only the CPU stops in wait
	assign cpu_tick = periph_tick;
	assign cpu_clk_en = periph_tick && (state_q == ST_RUN);
	assign periph_clk_en = periph_tick;
	assign motor_serial_clk_en = ms_tick;
	assign power_state = state_q;

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	// Each address and data beat is taken once and not again until the response
	// has been handed over, so one write at most is under way.
	assign s_axi_awready = !aw_done_q && !s_axi_bvalid;
	assign s_axi_wready = !w_done_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire = (aw_done_q || (s_axi_awvalid && s_axi_awready))
		&& (w_done_q || (s_axi_wvalid && s_axi_wready));

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_done_q <= 1'b0;
			w_done_q <= 1'b0;
			awaddr_q <= 4'h0;
			wdata_q <= 32'h00000000;
			wstrb_lo_q <= 1'b0;
			misc_q <= `PMVC_MISC_RESET;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q <= s_axi_awaddr;
				aw_done_q <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q <= s_axi_wdata;
				wstrb_lo_q <= s_axi_wstrb[0];
				w_done_q <= 1'b1;
			end
			if (wr_fire) begin
				aw_done_q <= 1'b0;
				w_done_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if ((aw_done_q ? awaddr_q : s_axi_awaddr) == `PMVC_OFS_MISC) begin
					s_axi_bresp <= 2'h0;
					// A data beat taken before its address keeps its own strobe.
					if (w_done_q ? wstrb_lo_q : s_axi_wstrb[0]) begin
						misc_q <= w_done_q ? wdata_q[2:0] : s_axi_wdata[2:0];
					end
				end else begin
					s_axi_bresp <= 2'h2;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// The wait request bit is one-shot: it clears once wait is entered.
			if (state_q == ST_WAIT && misc_q[`PMVC_BIT_WAITREQ] && !wr_fire) begin
				misc_q[`PMVC_BIT_WAITREQ] <= 1'b0;
			end
		end
	end

	// Read data is registered, so rvalid and rdata rise together on the same
	// edge that takes the address.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case (s_axi_araddr)
				`PMVC_OFS_MISC: s_axi_rdata <= {29'h00000000, misc_q};
				`PMVC_OFS_STATUS: s_axi_rdata <= {20'h00000, req, state_q};
				`PMVC_OFS_VECTOR: s_axi_rdata <= {16'h0000, cpu_vector};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // pmvc_power_ctrl

// ---- hdl/pmvc_regs.vh ----
`ifndef PMVC_REGS_VH
`define PMVC_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PMVC_OFS_MISC 4'h0
`define PMVC_OFS_STATUS 4'h4
`define PMVC_OFS_VECTOR 4'h8

// ----------------------------------------------------------------
// Miscellaneous control fields and reset value
// ----------------------------------------------------------------
`define PMVC_BIT_SLOW 0
`define PMVC_BIT_MSCLK 1
`define PMVC_BIT_WAITREQ 2
`define PMVC_MISC_RESET 3'h0

// ----------------------------------------------------------------
// Clock division and restart timing
// ----------------------------------------------------------------
`define PMVC_DIV_RUN 6'h02
`define PMVC_DIV_SLOW 6'h20
`define PMVC_DIV_FAST 6'h01
`define PMVC_STAB_CYCLES 4096

// ----------------------------------------------------------------
// Vector addresses
// ----------------------------------------------------------------
`define PMVC_VEC_RESET 16'hFFFE
`define PMVC_VEC_PGA 16'hFFFA
`define PMVC_VEC_PGB 16'hFFF8
`define PMVC_VEC_MRZ 16'hFFF4
`define PMVC_VEC_MCD 16'hFFF2
`define PMVC_VEC_MEO 16'hFFF0
`define PMVC_VEC_SPI 16'hFFEE
`define PMVC_VEC_TA 16'hFFEC
`define PMVC_VEC_TB 16'hFFEA
`define PMVC_NUM_SRC 8

`endif

// ---- hdl/pmvc_clk_div.v ----
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Divider producing a one-cycle enable every div_i cycles
// ----------------------------------------------------------------
module pmvc_clk_div (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Control
	input wire run,
	input wire [5:0] div_i,
	// Enable
	output wire tick
);
	reg [5:0] cnt_q;

	assign tick = run && (cnt_q >= div_i - 6'h01);

	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 6'h00;
		end else if (!run || tick) begin
			cnt_q <= 6'h00;
		end else begin
			cnt_q <= cnt_q + 6'h01;
		end
	end
endmodule // pmvc_clk_div

// ---- hdl/pmvc_irq_prio.v ----
`timescale 1ns/10ps
`include "pmvc_regs.vh"

// ----------------------------------------------------------------
// Fixed-priority selection of the pending source and its vector
// ----------------------------------------------------------------
module pmvc_irq_prio (
	// Requests, bit 0 highest priority
	input wire [7:0] req,
	// Selection
	output reg any,
	output reg [7:0] grant,
	output reg [15:0] vector
);
	function [15:0] vec_of;
		input [2:0] idx;
		begin
			case (idx)
				3'h0: vec_of = `PMVC_VEC_PGA;
				3'h1: vec_of = `PMVC_VEC_PGB;
				3'h2: vec_of = `PMVC_VEC_MRZ;
				3'h3: vec_of = `PMVC_VEC_MCD;
				3'h4: vec_of = `PMVC_VEC_MEO;
				3'h5: vec_of = `PMVC_VEC_SPI;
				3'h6: vec_of = `PMVC_VEC_TA;
				default: vec_of = `PMVC_VEC_TB;
			endcase
		end
	endfunction

	integer i;

	always @* begin
		any = 1'b0;
		grant = 8'h00;
		vector = `PMVC_VEC_RESET;
		for (i = `PMVC_NUM_SRC - 1; i >= 0; i = i - 1) begin
			if (req[i]) begin
				any = 1'b1;
				grant = 8'h01 << i;
				vector = vec_of(i[2:0]);
			end
		end
	end
endmodule // pmvc_irq_prio

// ---- bench/pmvc_cpu_model.sv ----
`timescale 1ns/10ps

// ----
// CPU core stand-in: interrupt mask and instruction boundaries
// ----
module pmvc_cpu_model (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Design side
	input wire cpu_irq_take,
	input wire cpu_irq_mask_clr,
	output wire cpu_irq_mask,
	output wire cpu_instr_end,
	// Bench side
	input wire interrupt_return_instruction
);
	reg mask_q;
	reg [1:0] ph_q;
	assign cpu_irq_mask = mask_q | cpu_irq_take;
	// Boundaries come one cycle in three, so a request must wait for one.
	assign cpu_instr_end = (ph_q == 2'h2);
	always @(posedge aclk) begin
		ph_q <= (!aresetn || ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
		if (!aresetn || cpu_irq_take)
			mask_q <= 1'b1;
		else if (cpu_irq_mask_clr || interrupt_return_instruction)
			mask_q <= 1'b0;
	end
endmodule // pmvc_cpu_model

// ---- bench/pmvc_power_ctrl_chk.sv ----
`timescale 1ns/10ps

// ----
// Port checker
// ----
module pmvc_power_ctrl_chk #(
	parameter STAB_CYCLES = 4096
) (
	input wire aclk,
	input wire aresetn,
	input wire cpu_halt_instr,
	input wire cpu_wait_instr,
	input wire cpu_irq_take,
	input wire cpu_irq_mask_clr,
	input wire [15:0] cpu_vector,
	input wire cpu_reset_fetch,
	input wire osc_enable,
	input wire cpu_clk_en,
	input wire periph_clk_en,
	input wire [3:0] power_state
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	reg [15:0] stab_q;
	// Counts peripheral enables seen during restart, which match the CPU ticks, so the checks hold in SLOW mode too.
	wire [15:0] stab_d = (power_state == 4'h8) ? stab_q + {15'h0000, periph_clk_en} : 16'h0000;
	always @(posedge aclk) begin
		stab_q <= aresetn ? stab_d : 16'h0;
	end
	property p_rst;
		$rose(aresetn) |-> cpu_reset_fetch && cpu_vector == 16'hFFFE && power_state == 4'h1;
	endproperty
	a_rst: assert property (p_rst) else $error("reset vector missing");
	property p_halt_in;
		power_state == 4'h1 && cpu_halt_instr |=> power_state == 4'h4 && cpu_irq_mask_clr;
	endproperty
	a_halt_in: assert property (p_halt_in) else $error("halt entry wrong");
	property p_wait_in;
		power_state == 4'h1 && !cpu_halt_instr && cpu_wait_instr
			|=> power_state == 4'h2 && cpu_irq_mask_clr;
	endproperty
	a_wait_in: assert property (p_wait_in) else $error("wait entry wrong");
	property p_halt_clk;
		power_state == 4'h4 |-> !osc_enable && !cpu_clk_en && !periph_clk_en;
	endproperty
	a_halt_clk: assert property (p_halt_clk) else $error("clock in halt");
	property p_wait_clk;
		power_state == 4'h2 |-> osc_enable && !cpu_clk_en;
	endproperty
	a_wait_clk: assert property (p_wait_clk) else $error("cpu clock in wait");
	property p_vec;
		cpu_irq_take |-> cpu_vector inside {16'hFFFA, 16'hFFF8, 16'hFFF4, 16'hFFF2,
			16'hFFF0, 16'hFFEE, 16'hFFEC, 16'hFFEA};
	endproperty
	a_vec: assert property (p_vec) else $error("unused vector");
	property p_mclr;
		cpu_irq_mask_clr |-> power_state == 4'h2 || power_state == 4'h4;
	endproperty
	a_mclr: assert property (p_mclr) else $error("stray mask clear");
	property p_stab_hold;
		power_state == 4'h8 && !(stab_q == STAB_CYCLES - 1 && periph_clk_en)
			|-> !cpu_irq_take ##1 power_state == 4'h8;
	endproperty
	a_stab_hold: assert property (p_stab_hold) else $error("early release");
	property p_stab_end;
		power_state == 4'h8 && stab_q == STAB_CYCLES - 1 && periph_clk_en
			|=> power_state == 4'h1 && cpu_irq_take;
	endproperty
	a_stab_end: assert property (p_stab_end) else $error("release missed");
endmodule // pmvc_power_ctrl_chk

bind pmvc_power_ctrl pmvc_power_ctrl_chk #(.STAB_CYCLES(STAB_CYCLES)) pmvc_power_ctrl_chk_i (
	.aclk(aclk), .aresetn(aresetn), .cpu_halt_instr(cpu_halt_instr),
	.cpu_wait_instr(cpu_wait_instr), .cpu_irq_take(cpu_irq_take),
	.cpu_irq_mask_clr(cpu_irq_mask_clr), .cpu_vector(cpu_vector),
	.cpu_reset_fetch(cpu_reset_fetch), .osc_enable(osc_enable), .cpu_clk_en(cpu_clk_en),
	.periph_clk_en(periph_clk_en), .power_state(power_state));

// ---- bench/pmvc_power_ctrl_tb.sv ----
`timescale 1ns/10ps

module pmvc_power_ctrl_tb;
	reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, halt_i, wait_i, interrupt_return_instruction;
	reg [3:0] awaddr, araddr;
	reg [31:0] wdata, d;
	reg [7:0] src, q;
	reg [15:0] v;
	reg [15:0] vt [0:7];
	reg [1:0] resp;
	reg [3:0] strb;
	wire awready, wready, bvalid, arready, rvalid, take, mclr, rfetch, mask, iend;
	wire osc, cpu_en, per_en, ms_en;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [15:0] vec;
	wire [3:0] st;
	integer err_total, check_count, seed, n, i, j, k, a, b, c;
	pmvc_power_ctrl #(.STAB_CYCLES(8)) pmvc_power_ctrl_i (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.cpu_halt_instr(halt_i), .cpu_wait_instr(wait_i), .cpu_instr_end(iend),
		.cpu_irq_mask(mask), .cpu_irq_mask_clr(mclr), .cpu_irq_take(take),
		.cpu_vector(vec), .cpu_reset_fetch(rfetch),
		.port_group_a_pin(src[0]), .port_group_b_pin(src[1]), .motor_irq(src[4:2]),
		.spi_irq(src[5]), .timer_one_irq(src[6]), .timer_two_irq(src[7]),
		.osc_enable(osc), .cpu_clk_en(cpu_en), .periph_clk_en(per_en),
		.motor_serial_clk_en(ms_en), .power_state(st));
	pmvc_cpu_model pmvc_cpu_model_i (.aclk(aclk), .aresetn(aresetn), .cpu_irq_take(take),
		.cpu_irq_mask_clr(mclr), .cpu_irq_mask(mask), .cpu_instr_end(iend), .interrupt_return_instruction(interrupt_return_instruction));
	task complete_run;
		begin
			$display("mismatches %0d comparisons %0d", err_total, check_count);
			if (err_total == 0 && check_count > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task chk(input [39:0] g, input [39:0] e);
		begin
			check_count = check_count + 1;
			if (g !== e) begin
				err_total = err_total + 1;
				$display("unexpected at %0t: got %h want %h", $time, g, e);
			end
		end
	endtask
	task tmo;
		begin
			err_total = err_total + 1;
			complete_run;
		end
	endtask
	task wr(input [3:0] ad, input [31:0] dt);
		reg ga, gw, gb, ta, tw;
		begin
			@(posedge aclk);
			awaddr <= ad;
			wdata <= dt;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			{ga, gw, gb} = 3'h0;
			for (n = 0; n < 50 && !gb; n = n + 1) begin
				@(negedge aclk);
				ta = awready & !ga;
				tw = wready & !gw;
				gb = bvalid & ga & gw;
				resp = bresp;
				@(posedge aclk);
				awvalid <= !(ga | ta);
				wvalid <= !(gw | tw);
				bready <= !gb;
				ga = ga | ta;
				gw = gw | tw;
			end
			if (!gb) tmo;
		end
	endtask
	task rd(input [3:0] ad);
		reg ga, gb, ta;
		begin
			@(posedge aclk);
			araddr <= ad;
			arvalid <= 1'b1;
			rready <= 1'b1;
			{ga, gb} = 2'h0;
			for (n = 0; n < 50 && !gb; n = n + 1) begin
				@(negedge aclk);
				ta = arready & !ga;
				gb = rvalid & ga;
				resp = rresp;
				d = rdata;
				@(posedge aclk);
				arvalid <= !(ga | ta);
				rready <= !gb;
				ga = ga | ta;
			end
			if (!gb) tmo;
		end
	endtask
	task cnt;
		begin
			{a, b, c} = 0;
			repeat (64) begin
				@(negedge aclk);
				a = a + cpu_en;
				b = b + per_en;
				c = c + ms_en;
			end
			@(posedge aclk);
		end
	endtask
	task stc(input [3:0] e);
		begin
			@(negedge aclk);
			chk(st, e);
			@(posedge aclk);
		end
	endtask
	task wt;
		reg h;
		begin
			h = 1'b0;
			for (k = 0; k < 200 && !h; k = k + 1) begin
				@(negedge aclk);
				h = (take === 1'b1);
				v = vec;
			end
			@(posedge aclk);
			if (!h) tmo;
		end
	endtask
	// The model serves pending sources lowest index first, which is the fixed priority.
	task serve(input [7:0] set);
		begin
			@(posedge aclk);
			src <= set;
			q = set;
			while (q != 8'h00) begin
				interrupt_return_instruction <= 1'b1;
				@(posedge aclk);
				interrupt_return_instruction <= 1'b0;
				for (j = 0; !q[j]; j = j + 1) ;
				wt;
				chk(v, vt[j]);
				q[j] = 1'b0;
				src <= q;
			end
		end
	endtask
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, halt_i, wait_i, interrupt_return_instruction} = 0;
		{awaddr, araddr, wdata, src} = 0;
		strb = 4'hF;
		{err_total, check_count} = 0;
		seed = 32'hd28ef1cf;
		vt = '{16'hFFFA, 16'hFFF8, 16'hFFF4, 16'hFFF2, 16'hFFF0, 16'hFFEE, 16'hFFEC, 16'hFFEA};
		repeat (7) @(posedge aclk);
		@(negedge aclk);
		chk({rfetch, vec, st}, {1'b1, 16'hFFFE, 4'h1});
		@(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		cnt;
		chk({a[7:0], b[7:0], c[7:0]}, 24'h202020);
		wr(4'h0, 32'h1);
		cnt;
		chk({resp, a[7:0], b[7:0], c[7:0]}, 26'h0020220);
		wr(4'h0, 32'h3);
		cnt;
		chk({a[7:0], b[7:0], c[7:0]}, 24'h020240);
		rd(4'h0);
		chk({resp, d}, {2'h0, 32'h3});
		wr(4'h0, 32'h0);
		wr(4'hC, 32'h5);
		rd(4'hC);
		chk({bresp, resp, d}, {2'h2, 2'h2, 32'h0});
		strb <= 4'h0;
		wr(4'h0, 32'h1);
		rd(4'h0);
		chk(d, 32'h0);
		strb <= 4'hF;
		for (i = 0; i < 14; i = i + 1) begin
			d = $random(seed);
			serve(i < 8 ? 8'h01 << i : d[7:0]);
		end
		rd(4'h8);
		chk(d, {16'h0, v});
		halt_i <= 1'b1;
		@(posedge aclk);
		halt_i <= 1'b0;
		src <= 8'h44;
		repeat (30) @(posedge aclk);
		stc(4'h4);
		src <= 8'h45;
		wt;
		chk({k[7:0], v}, {8'h13, 16'hFFFA});
		serve(8'h44);
		wait_i <= 1'b1;
		@(posedge aclk);
		wait_i <= 1'b0;
		stc(4'h2);
		cnt;
		chk({a[7:0], b[7:0], c[7:0]}, 24'h002020);
		serve(8'h20);
		stc(4'h1);
		wr(4'h0, 32'h4);
		stc(4'h2);
		rd(4'h0);
		chk(d, 32'h0);
		serve(8'h80);
		stc(4'h1);
		halt_i <= 1'b1;
		@(posedge aclk);
		halt_i <= 1'b0;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk({rfetch, vec, st}, {1'b1, 16'hFFFE, 4'h1});
		@(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		@(negedge aclk);
		chk({rfetch, st}, {1'b0, 4'h1});
		complete_run;
	end
endmodule // pmvc_power_ctrl_tb
